// *** logic/csp_core_state.sv ***
/*
 Accumulator, flag register, stack status register and program counter.
 Assumes the decoder issues one instruction per cycle with single-cycle
 strobes, and the reset controller reports the cause with rst.
*/
// Strobed register access was decided locally.
`timescale 1ns/100ps
module csp_core_state (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire csp_pkg::csp_bus_t    bus,
    output logic      [7:0]           rdata_q,
    input  wire csp_pkg::csp_alu_req_t alu_req,
    input  wire logic                 alu_go,
    input  wire csp_pkg::csp_skip_t   skip_kind,
    input  wire logic [7:0]           skip_operand,
    input  wire logic [2:0]           skip_bit,
    input  wire csp_pkg::csp_pc_op_t  pc_op,
    input  wire logic [12:0]          pc_target,
    input  wire logic                 pc_low_sub,
    input  wire logic                 push,
    input  wire logic                 pop,
    input  wire logic                 int_entry,
    input  wire logic                 int_return,
    input  wire logic [7:0]           work_in [16],
    output logic      [7:0]           work_saved_q [16],
    input  wire csp_pkg::csp_cause_t  reset_cause,
    input  wire logic                 supply_low_pin,
    input  wire logic                 supply_high_pin,
    output logic      [7:0]           acc_q,
    output logic      [12:0]          pc_q,
    output logic                      gie_q,
    output logic      [2:0]           sp_q
);
    import csp_pkg::*;

    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_dc;
    logic       alu_wc;
    logic       c_q;
    logic       dc_q;
    logic       z_q;
    logic       por_q;
    logic       wdt_q;
    logic       pin_q;
    logic       stack_overflow_flag_q;
    logic [1:0] lvl_s;
    logic [1:0] lvh_s;
    logic [7:0] acc_saved_q;
    logic       skip_d;
    logic [8:0] add_chk;
    logic [4:0] nib_chk;
    logic       cmp_flag_wr;

    csp_alu u_alu (
        .op       (alu_req.op),
        .a        (acc_q),
        .b        (alu_req.operand),
        .cin      (c_q),
        .res      (alu_res),
        .c        (alu_c),
        .dc       (alu_dc),
        .writes_c (alu_wc)
    );

    // Supply comparators are asynchronous to the core clock
    always_ff @(posedge clock) begin
        lvl_s <= {lvl_s[0], supply_low_pin};
        lvh_s <= {lvh_s[0], supply_high_pin};
    end

    // Accumulator; result lands in memory when to_acc is low
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_q <= BYTE_00;
        end else if (int_return) begin
            acc_q <= acc_saved_q;
        end else if (alu_go && alu_req.to_acc
                     && alu_req.op != CSP_OP_CMP) begin
            acc_q <= alu_res;
        end
    end

    // Hardware context save on interrupt entry
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_saved_q <= BYTE_00;
        end else if (int_entry) begin
            acc_saved_q <= acc_q;
        end
    end

    generate
        for (genvar i = 0; i < WORK_REGS; i++) begin : g_work
            always_ff @(posedge clock) begin
                if (rst) begin
                    work_saved_q[i] <= BYTE_00;
                end else if (int_entry) begin
                    work_saved_q[i] <= work_in[i];
                end
            end
            save_word_a: assert property (
                @(posedge clock) disable iff (rst)
                int_entry |=> work_saved_q[i] == $past(work_in[i]))
                else $error("working register not saved");
        end
    endgenerate

    // ALU writes win over a same-cycle software write
    assign cmp_flag_wr = bus.wr && bus.addr == ADDR_FLAGS;
    always_ff @(posedge clock) begin
        if (rst) begin
            c_q  <= 1'b0;
            dc_q <= 1'b0;
            z_q  <= 1'b0;
        end else if (alu_go) begin
            if (alu_wc) begin
                c_q  <= alu_c;
                dc_q <= alu_dc;
            end
            z_q <= (alu_res == BYTE_00);
        end else if (cmp_flag_wr) begin
            c_q  <= bus.wdata[FLG_C];
            dc_q <= bus.wdata[FLG_DC];
            z_q  <= bus.wdata[FLG_Z];
        end
    end

    // Reset cause latched while reset is held
    always_ff @(posedge clock) begin
        if (rst) begin
            por_q <= (reset_cause == CSP_RC_POWER);
            wdt_q <= (reset_cause == CSP_RC_WATCHDOG);
            pin_q <= (reset_cause == CSP_RC_PIN);
        end
    end

    // Stack pointer counts down on push; zero level means full
    always_ff @(posedge clock) begin
        if (rst) begin
            sp_q    <= SP_RESET;
            stack_overflow_flag_q <= 1'b0;
        end else if (push) begin
            if (sp_q == 3'h0) begin
                stack_overflow_flag_q <= 1'b1;
            end
            sp_q <= sp_q - 3'h1;
        end else if (pop) begin
            sp_q <= sp_q + 3'h1;
        end else if (bus.wr && bus.addr == ADDR_STACK_POINTER_AND_SUPPLY_STATUS) begin
            sp_q <= bus.wdata[2:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gie_q <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_STACK_POINTER_AND_SUPPLY_STATUS) begin
            gie_q <= bus.wdata[STK_GIE];
        end
    end

    // Skip condition evaluation
    always_comb begin
        case (skip_kind)
            CSP_SK_CMP:  skip_d = (acc_q == skip_operand);
            CSP_SK_INC:  skip_d = (skip_operand == BYTE_FF);
            CSP_SK_DEC:  skip_d = (skip_operand == BYTE_01);
            CSP_SK_BIT0: skip_d = !skip_operand[skip_bit];
            CSP_SK_BIT1: skip_d = skip_operand[skip_bit];
            default:     skip_d = 1'b0;
        endcase
    end

    // Reference sums kept apart from the ALU so checks catch its slips
    assign add_chk = {1'b0, acc_q} + {1'b0, alu_req.operand};
    assign nib_chk = {1'b0, acc_q[3:0]} + {1'b0, alu_req.operand[3:0]};

    // Program counter
    always_ff @(posedge clock) begin
        if (rst) begin
            pc_q <= PC_RESET;
        end else begin
            case (pc_op)
                CSP_PC_LOAD: pc_q <= pc_target;
                CSP_PC_LOWADD: begin
                    // Result already summed by ALU; carry from alu_c
                    pc_q[7:0] <= alu_res;
                    if (!pc_low_sub && alu_c) begin
                        pc_q[12:8] <= pc_q[12:8] + 5'h01;
                    end
                end
                CSP_PC_HOLD: pc_q <= pc_q;
                default: begin
                    if (skip_d) begin
                        pc_q <= pc_q + PC_SKIP;
                    end else begin
                        pc_q <= pc_q + PC_STEP;
                    end
                end
            endcase
        end
    end

    // Register read port; accumulator is not decoded
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= BYTE_00;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_FLAGS: rdata_q <= {por_q, wdt_q, pin_q, stack_overflow_flag_q,
                                        1'b0, c_q, dc_q, z_q};
                ADDR_STACK_POINTER_AND_SUPPLY_STATUS:  rdata_q <= {gie_q, lvl_s[1], lvh_s[1],
                                        2'b00, sp_q};
                ADDR_PCL:   rdata_q <= pc_q[7:0];
                ADDR_PCH:   rdata_q <= {3'b000, pc_q[12:8]};
                default:    rdata_q <= BYTE_00;
            endcase
        end else begin
            rdata_q <= BYTE_00;
        end
    end

    // Reset checks carry no disable so the clear itself is watched
    pc_reset_a: assert property (
        @(posedge clock)
        rst |=> pc_q == PC_RESET)
        else $error("pc not cleared");
    stk_reset_a: assert property (
        @(posedge clock)
        rst |=> sp_q == SP_RESET && !gie_q)
        else $error("stack register not reset");
    zero_flag_a: assert property (
        @(posedge clock) disable iff (rst)
        alu_go |=> z_q == ($past(alu_res) == 8'h00))
        else $error("zero flag mismatch");
    acc_mov_a: assert property (
        @(posedge clock) disable iff (rst)
        alu_go && alu_req.to_acc && alu_req.op == CSP_OP_MOV
        && !int_return |=> acc_q == $past(alu_req.operand))
        else $error("accumulator not loaded");
    add_carry_a: assert property (
        @(posedge clock) disable iff (rst)
        alu_go && alu_req.op == CSP_OP_ADD
        |=> c_q == $past(add_chk[8]))
        else $error("add carry wrong");
    add_dc_a: assert property (
        @(posedge clock) disable iff (rst)
        alu_go && alu_req.op == CSP_OP_ADD
        |=> dc_q == $past(nib_chk[4]))
        else $error("add decimal carry wrong");
    sub_carry_a: assert property (
        @(posedge clock) disable iff (rst)
        alu_go && alu_req.op == CSP_OP_SUB
        |=> c_q == $past(acc_q >= alu_req.operand))
        else $error("subtract carry wrong");
    flag_wr_a: assert property (
        @(posedge clock) disable iff (rst)
        cmp_flag_wr && !alu_go
        |=> {c_q, dc_q, z_q} == $past(bus.wdata[FLG_C:FLG_Z]))
        else $error("flag write lost");
    cause_one_a: assert property (
        @(posedge clock) disable iff (rst)
        $onehot0({por_q, wdt_q, pin_q}))
        else $error("more than one reset cause");
    sp_push_a: assert property (
        @(posedge clock) disable iff (rst)
        push |=> sp_q == $past(sp_q) - 3'h1)
        else $error("stack pointer push wrong");
    gie_wr_a: assert property (
        @(posedge clock) disable iff (rst)
        bus.wr && bus.addr == ADDR_STACK_POINTER_AND_SUPPLY_STATUS
        |=> gie_q == $past(bus.wdata[STK_GIE]))
        else $error("interrupt enable write lost");
    supply_bits_a: assert property (
        @(posedge clock) disable iff (rst)
        bus.rd && bus.addr == ADDR_STACK_POINTER_AND_SUPPLY_STATUS
        |=> rdata_q[STK_LVL] == $past(supply_low_pin, 3))
        else $error("supply indicator wrong");
    rd_acc_a: assert property (
        @(posedge clock) disable iff (rst)
        bus.rd && bus.addr == ADDR_ACC
        |=> rdata_q == BYTE_00)
        else $error("accumulator visible on bus");
    pc_step_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && !skip_d
        |=> pc_q == $past(pc_q) + 13'h0001)
        else $error("pc step wrong");
    pc_skip_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_d
        |=> pc_q == $past(pc_q) + 13'h0002)
        else $error("pc skip wrong");
    inc_skip_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_kind == CSP_SK_INC
        && skip_operand == BYTE_FF |=> pc_q == $past(pc_q) + PC_SKIP)
        else $error("increment skip missed");
    dec_skip_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_kind == CSP_SK_DEC
        && skip_operand == BYTE_01 |=> pc_q == $past(pc_q) + PC_SKIP)
        else $error("decrement skip missed");
    bit_skip_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_kind == CSP_SK_BIT0
        && !skip_operand[skip_bit] |=> pc_q == $past(pc_q) + PC_SKIP)
        else $error("bit test skip missed");
    pc_load_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_LOAD
        |=> pc_q == $past(pc_target))
        else $error("pc load wrong");
    pc_borrow_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_LOWADD && pc_low_sub
        |=> $stable(pc_q[12:8]))
        else $error("high byte moved on borrow");
    pc_carry_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_LOWADD && !pc_low_sub && alu_c
        |=> pc_q[12:8] == $past(pc_q[12:8]) + 5'h01)
        else $error("high byte no carry");
    stk_ovf_a: assert property (
        @(posedge clock) disable iff (rst)
        push && sp_q == 3'h0
        |=> stack_overflow_flag_q)
        else $error("overflow not set");
    ctx_save_a: assert property (
        @(posedge clock) disable iff (rst)
        int_entry
        |=> acc_saved_q == $past(acc_q))
        else $error("context save wrong");
    ctx_restore_a: assert property (
        @(posedge clock) disable iff (rst)
        int_return
        |=> acc_q == $past(acc_saved_q))
        else $error("context restore wrong");
    cmp_skip_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_kind == CSP_SK_CMP
        && acc_q != skip_operand |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("compare skipped wrongly");
    cmp_hit_a: assert property (
        @(posedge clock) disable iff (rst)
        pc_op == CSP_PC_STEP && skip_kind == CSP_SK_CMP
        && acc_q == skip_operand |=> pc_q == $past(pc_q) + PC_SKIP)
        else $error("compare skip missed");
endmodule

// *** logic/csp_pkg.sv ***
/*
 Constants, types and register map for the core status and program
 counter block. Assumes one clock domain and synchronous reset.
*/
package csp_pkg;
    localparam logic [7:0] ADDR_FLAGS   = 8'h86;
    localparam logic [7:0] ADDR_STACK_POINTER_AND_SUPPLY_STATUS    = 8'hef;
    localparam logic [7:0] ADDR_PCL     = 8'hce;
    localparam logic [7:0] ADDR_PCH     = 8'hcf;
    localparam logic [7:0] ADDR_ACC     = 8'hc0;
    localparam logic [7:0] WORK_FIRST   = 8'h80;
    localparam int         WORK_REGS    = 16;
    localparam int         FLG_POR      = 7;
    localparam int         FLG_WDT      = 6;
    localparam int         FLG_RST      = 5;
    localparam int         FLG_STACK_OVERFLOW_FLAG    = 4;
    localparam int         FLG_C        = 2;
    localparam int         FLG_DC       = 1;
    localparam int         FLG_Z        = 0;
    localparam int         STK_GIE      = 7;
    localparam int         STK_LVL      = 6;
    localparam int         STK_LVH      = 5;
    localparam logic [2:0] SP_RESET     = 3'h7;
    localparam logic [12:0] PC_RESET    = 13'h0000;
    localparam logic [12:0] PC_STEP     = 13'h0001;
    localparam logic [12:0] PC_SKIP     = 13'h0002;
    localparam logic [7:0] BYTE_FF      = 8'hff;
    localparam logic [7:0] BYTE_01      = 8'h01;
    localparam logic [7:0] BYTE_00      = 8'h00;

    typedef enum logic [3:0] {
        CSP_OP_NONE, CSP_OP_ADD, CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SBC,
        CSP_OP_AND, CSP_OP_OR, CSP_OP_XOR, CSP_OP_RLC, CSP_OP_RRC,
        CSP_OP_CMP, CSP_OP_INC, CSP_OP_DEC, CSP_OP_MOV
    } csp_alu_op_t;

    typedef enum logic [2:0] {
        CSP_SK_NONE, CSP_SK_CMP, CSP_SK_INC, CSP_SK_DEC,
        CSP_SK_BIT0, CSP_SK_BIT1
    } csp_skip_t;

    typedef enum logic [1:0] {
        CSP_PC_STEP, CSP_PC_LOAD, CSP_PC_LOWADD, CSP_PC_HOLD
    } csp_pc_op_t;

    typedef struct packed {
        csp_alu_op_t op;
        logic [7:0]  operand;
        logic        to_acc;
    } csp_alu_req_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } csp_bus_t;

    typedef enum logic [1:0] {
        CSP_RC_POWER, CSP_RC_WATCHDOG, CSP_RC_PIN, CSP_RC_NONE
    } csp_cause_t;
endpackage

// *** logic/csp_alu.sv ***
/*
 Combinational 8-bit ALU producing result and carry flags.
 Assumes the caller registers the outputs.
*/
`timescale 1ns/100ps
module csp_alu (
    input  wire csp_pkg::csp_alu_op_t op,
    input  wire logic [7:0]           a,
    input  wire logic [7:0]           b,
    input  wire logic                 cin,
    output logic      [7:0]           res,
    output logic                      c,
    output logic                      dc,
    output logic                      writes_c
);
    import csp_pkg::*;
    logic [8:0] wide;
    logic [4:0] nib;
    always_comb begin
        wide     = 9'h000;
        nib      = 5'h00;
        res      = a;
        c        = cin;
        dc       = 1'b0;
        writes_c = 1'b1;
        case (op)
            CSP_OP_ADD, CSP_OP_ADC: begin
                // Carry out and low nibble carry
                wide = {1'b0, a} + {1'b0, b} + {8'h00, op == CSP_OP_ADC && cin};
                nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]}
                     + {4'h0, op == CSP_OP_ADC && cin};
                res  = wide[7:0];
                c    = wide[8];
                dc   = nib[4];
            end
            CSP_OP_SUB, CSP_OP_SBC, CSP_OP_CMP: begin
                // Carry means no borrow
                wide = {1'b0, a} - {1'b0, b}
                     - {8'h00, op == CSP_OP_SBC && !cin};
                nib  = {1'b0, a[3:0]} - {1'b0, b[3:0]}
                     - {4'h0, op == CSP_OP_SBC && !cin};
                res  = wide[7:0];
                c    = !wide[8];
                dc   = !nib[4];
            end
            CSP_OP_RLC: begin
                res = {a[6:0], cin};
                c   = a[7];
            end
            CSP_OP_RRC: begin
                res = {cin, a[7:1]};
                c   = a[0];
            end
            CSP_OP_AND: begin
                res = a & b;
                writes_c = 1'b0;
            end
            CSP_OP_OR: begin
                res = a | b;
                writes_c = 1'b0;
            end
            CSP_OP_XOR: begin
                res = a ^ b;
                writes_c = 1'b0;
            end
            CSP_OP_INC: begin
                res = a + 8'h01;
                writes_c = 1'b0;
            end
            CSP_OP_DEC: begin
                res = a - 8'h01;
                writes_c = 1'b0;
            end
            CSP_OP_MOV: begin
                res = b;
                writes_c = 1'b0;
            end
            default: begin
                writes_c = 1'b0;
            end
        endcase
    end
endmodule

// *** testbench/csp_dec_model.sv ***
/*
 Stand-in for the instruction decoder and data memory.
 Assumes one caller at a time; each request lasts one clock.
*/
`timescale 1ns/100ps
module csp_dec_model (
    input  wire logic             clock,
    output csp_pkg::csp_alu_req_t alu_req,
    output logic                  alu_go,
    output csp_pkg::csp_skip_t    skip_kind,
    output logic [7:0]            skip_operand,
    output logic [2:0]            skip_bit,
    output csp_pkg::csp_pc_op_t   pc_op,
    output logic [12:0]           pc_target,
    output logic [4:0]            pulses,
    output logic [7:0]            work_in [16]
);
    import csp_pkg::*;
    // Idle holds the counter so the bench sees a still value
    task automatic idle();
        alu_go <= 1'b0;
        skip_kind <= CSP_SK_NONE;
        pc_op <= CSP_PC_HOLD;
        pulses <= 5'h00;
    endtask
    initial begin
        idle();
        alu_req <= '0;
        skip_operand <= 8'h00;
        skip_bit <= 3'h0;
        pc_target <= 13'h0000;
        for (int i = 0; i < 16; i++) begin
            work_in[i] <= 8'h30 + 8'(i);
        end
    end
    task automatic run(input csp_pc_op_t p, input logic [12:0] t,
                       input logic g, input csp_alu_req_t r,
                       input csp_skip_t k, input logic [7:0] so,
                       input logic [2:0] sb, input logic [4:0] pl);
        @(posedge clock);
        pc_op <= p;
        pc_target <= t;
        alu_go <= g;
        alu_req <= r;
        skip_kind <= k;
        skip_operand <= so;
        skip_bit <= sb;
        pulses <= pl;
        @(posedge clock);
        idle();
        @(negedge clock);
    endtask
endmodule

// *** testbench/tb.sv ***
/*
 Bench for the core status and program counter block.
 Assumes reads answer one cycle after the strobe.
*/
`timescale 1ns/100ps
module tb;
    import csp_pkg::*;
    logic         clock, rst, alu_go, gie_q, low_pin, high_pin;
    csp_bus_t     bus;
    csp_cause_t   cause;
    csp_alu_req_t alu_req;
    csp_skip_t    skip_kind;
    csp_pc_op_t   pc_op;
    logic [7:0]   rdata_q, acc_q, skip_operand;
    logic [2:0]   skip_bit, sp_q;
    logic [12:0]  pc_q, pc_target, pc_x;
    logic [4:0]   pulses;
    logic [7:0]   work_in [16];
    logic [7:0]   work_saved_q [16];
    int           errors, comparisons;
    int           cycles = 0;
    csp_alu_op_t ops [12] = '{CSP_OP_ADD, CSP_OP_ADD, CSP_OP_ADD,
        CSP_OP_ADC, CSP_OP_SUB, CSP_OP_SUB, CSP_OP_RLC, CSP_OP_RRC,
        CSP_OP_RRC, CSP_OP_CMP, CSP_OP_CMP, CSP_OP_AND};
    logic [7:0] opd [12] = '{8'h0f, 8'h01, 8'hf0, 8'h00, 8'h02, 8'h0f,
        8'h00, 8'h00, 8'h00, 8'hf8, 8'hf9, 8'h07};
    logic [7:0] accx [12] = '{8'h0f, 8'h10, 8'h00, 8'h01, 8'hff, 8'hf0,
        8'he1, 8'hf0, 8'hf8, 8'hf8, 8'hf8, 8'h00};
    logic [7:0] fx [12] = '{8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'h06,
        8'h04, 8'h04, 8'h00, 8'h05, 8'h00, 8'h01};
    logic [7:0] mk [12] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07,
        8'h04, 8'h04, 8'h04, 8'h05, 8'h05, 8'h01};
    csp_skip_t skk [12] = '{CSP_SK_CMP, CSP_SK_CMP, CSP_SK_INC,
        CSP_SK_INC, CSP_SK_DEC, CSP_SK_DEC, CSP_SK_DEC, CSP_SK_BIT0,
        CSP_SK_BIT0, CSP_SK_BIT1, CSP_SK_BIT1, CSP_SK_NONE};
    logic [7:0] sko [12] = '{8'h00, 8'h01, 8'hff, 8'hfe, 8'h01, 8'h02,
        8'h00, 8'hf7, 8'h08, 8'h08, 8'hf7, 8'h00};
    logic [1:0] stp [12] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1,
        2'h2, 2'h1, 2'h2, 2'h1, 2'h1};

    csp_core_state u_dut (.clock(clock), .rst(rst), .bus(bus),
        .rdata_q(rdata_q), .alu_req(alu_req), .alu_go(alu_go),
        .skip_kind(skip_kind), .skip_operand(skip_operand),
        .skip_bit(skip_bit), .pc_op(pc_op), .pc_target(pc_target),
        .pc_low_sub(pulses[4]), .push(pulses[3]), .pop(pulses[2]),
        .int_entry(pulses[1]), .int_return(pulses[0]),
        .work_in(work_in), .work_saved_q(work_saved_q),
        .reset_cause(cause), .supply_low_pin(low_pin),
        .supply_high_pin(high_pin), .acc_q(acc_q), .pc_q(pc_q),
        .gie_q(gie_q), .sp_q(sp_q));
    csp_dec_model u_dec (.clock(clock), .alu_req(alu_req),
        .alu_go(alu_go), .skip_kind(skip_kind),
        .skip_operand(skip_operand), .skip_bit(skip_bit),
        .pc_op(pc_op), .pc_target(pc_target), .pulses(pulses),
        .work_in(work_in));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask
    // Read data stand one cycle only, so sample at the next low phase
    task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        chk("rdata", 16'(e), 16'(rdata_q & m));
    endtask
    task automatic alu(input csp_alu_op_t o, input logic [7:0] v);
        u_dec.run(CSP_PC_HOLD, 13'h0000, 1'b1, '{o, v, 1'b1},
                  CSP_SK_NONE, 8'h00, 3'h0, 5'h00);
    endtask
    task automatic ctl(input csp_pc_op_t p, input logic [12:0] t,
                       input logic [4:0] pl);
        u_dec.run(p, t, 1'b0, '0, CSP_SK_NONE, 8'h00, 3'h0, pl);
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        rst = 1'b1;
        bus = '0;
        cause = CSP_RC_POWER;
        low_pin = 1'b0;
        high_pin = 1'b0;
        errors = 0;
        comparisons = 0;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            rst <= 1'b1;
            cause <= csp_cause_t'(i);
            repeat (3) @(posedge clock);
            rst <= 1'b0;
            rchk(ADDR_FLAGS, 8'hf7, 8'h80 >> i);
            rchk(ADDR_STACK_POINTER_AND_SUPPLY_STATUS, 8'he7, 8'h07);
            chk("pc", 16'h0000, 16'(pc_q));
            chk("state", 16'h0007, {acc_q, 4'h0, gie_q, sp_q});
        end
        wr(ADDR_FLAGS, 8'hff);
        rchk(ADDR_FLAGS, 8'hf7, 8'h27);
        wr(ADDR_FLAGS, 8'h00);
        rchk(ADDR_ACC, 8'hff, 8'h00);
        rchk(8'h87, 8'hff, 8'h00);
        for (int i = 0; i < 12; i++) begin
            alu(ops[i], opd[i]);
            chk("acc", 16'(accx[i]), 16'(acc_q));
            rchk(ADDR_FLAGS, mk[i], fx[i]);
        end
        pc_x = 13'h1000;
        ctl(CSP_PC_LOAD, pc_x, 5'h00);
        for (int i = 0; i < 12; i++) begin
            u_dec.run(CSP_PC_STEP, 13'h0000, 1'b0, '0, skk[i], sko[i],
                      3'h3, 5'h00);
            pc_x = pc_x + 13'(stp[i]);
            chk("pc_skip", 16'(pc_x), 16'(pc_q));
        end
        ctl(CSP_PC_LOAD, 13'h1fff, 5'h00);
        chk("pc_load", 16'h1fff, 16'(pc_q));
        alu(CSP_OP_MOV, 8'hf0);
        ctl(CSP_PC_LOAD, 13'h03f0, 5'h00);
        u_dec.run(CSP_PC_LOWADD, 13'h0000, 1'b1,
                  '{CSP_OP_ADD, 8'hf0, 1'b0}, CSP_SK_NONE, 8'h00, 3'h0,
                  5'h00);
        chk("pc_add", 16'h04e0, 16'(pc_q));
        alu(CSP_OP_MOV, 8'he0);
        u_dec.run(CSP_PC_LOWADD, 13'h0000, 1'b1,
                  '{CSP_OP_SUB, 8'he0, 1'b0}, CSP_SK_NONE, 8'h00, 3'h0,
                  5'h10);
        chk("pc_sub", 16'h0400, 16'(pc_q));
        rchk(ADDR_PCH, 8'hff, 8'h04);
        // Seven pushes fill the stack; the eighth must flag overflow
        for (int i = 0; i < 7; i++) begin
            ctl(CSP_PC_HOLD, 13'h0000, 5'h08);
        end
        rchk(ADDR_FLAGS, 8'h10, 8'h00);
        ctl(CSP_PC_HOLD, 13'h0000, 5'h08);
        rchk(ADDR_FLAGS, 8'h10, 8'h10);
        wr(ADDR_STACK_POINTER_AND_SUPPLY_STATUS, 8'h85);
        rchk(ADDR_STACK_POINTER_AND_SUPPLY_STATUS, 8'he7, 8'h85);
        ctl(CSP_PC_HOLD, 13'h0000, 5'h04);
        chk("gie_sp", 16'h000e, {12'h000, gie_q, sp_q});
        @(posedge clock);
        low_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rchk(ADDR_STACK_POINTER_AND_SUPPLY_STATUS, 8'he7, 8'hc6);
        @(posedge clock);
        low_pin <= 1'b0;
        high_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rchk(ADDR_STACK_POINTER_AND_SUPPLY_STATUS, 8'he7, 8'ha6);
        alu(CSP_OP_MOV, 8'h5a);
        ctl(CSP_PC_HOLD, 13'h0000, 5'h02);
        for (int i = 0; i < 16; i++) begin
            chk("saved", 16'(8'h30 + 8'(i)), 16'(work_saved_q[i]));
        end
        alu(CSP_OP_MOV, 8'h00);
        ctl(CSP_PC_HOLD, 13'h0000, 5'h01);
        chk("acc_back", 16'h005a, 16'(acc_q));
        finish_test();
    end
endmodule
